// file: gsrp_pkg.sv
// Shared constants, types and helpers for the gas sensor register port.
package gsrp_pkg;

  // Target address and pointer range.
  localparam logic [6:0] TARGET_ADDR_DEFAULT = 7'h33;
  localparam logic [7:0] PTR_FIRST           = 8'h00;
  localparam logic [7:0] PTR_LAST            = 8'hFF;
  localparam logic [7:0] PTR_STEP            = 8'h01;

  // Scratch registers used by software to check its bus driver.
  localparam logic [7:0] SCRATCH_TEST_0_OFS  = 8'h88;
  localparam logic [7:0] SCRATCH_TEST_1_OFS  = 8'h89;
  localparam logic [7:0] SCRATCH_TEST_2_OFS  = 8'h8A;
  localparam logic [7:0] SCRATCH_TEST_3_OFS  = 8'h8B;

  // Factory memory window and its field layout, byte offsets in the window.
  localparam int         NVM_BYTES           = 32;
  localparam logic [7:0] NVM_BASE            = 8'h00;
  localparam logic [7:0] NVM_LAST            = 8'h1F;
  localparam logic [7:0] NVM_CAL_COND_OFS    = 8'h00;
  localparam logic [7:0] NVM_TRACK_ID_OFS    = 8'h04;
  localparam logic [7:0] NVM_RESIST_OFS      = 8'h0A;
  localparam logic [7:0] NVM_SLOPE_OFS       = 8'h12;
  localparam logic [7:0] NVM_ICEPT_OFS       = 8'h16;

  // Bit counting inside a byte.
  localparam logic [3:0] BIT_CNT_ZERO        = 4'h0;
  localparam logic [3:0] BIT_CNT_ONE         = 4'h1;
  localparam logic [3:0] BIT_CNT_BYTE        = 4'h8;

  // Bus clock rates that the sampling logic must follow, in kHz.
  localparam int         SCL_STD_KHZ         = 100;
  localparam int         SCL_FAST_KHZ        = 400;

  // Serial engine states, one-hot.
  typedef enum logic [6:0] {
    LS_IDLE    = 7'h01,
    LS_ADDR    = 7'h02,
    LS_ADDRACK = 7'h04,
    LS_WDATA   = 7'h08,
    LS_WACK    = 7'h10,
    LS_RDATA   = 7'h20,
    LS_RACK    = 7'h40
  } gsrp_lstate_t;

  // One register access passed from the serial side to the memory side.
  typedef struct packed {
    logic       write;
    logic [7:0] addr;
    logic [7:0] data;
  } gsrp_req_t;

  // State of the serial engine, clocked by the link clock.
  typedef struct packed {
    logic         sclMeta;
    logic         sclSync;
    logic         sclPrev;
    logic         sdaMeta;
    logic         sdaSync;
    logic         sdaPrev;
    gsrp_lstate_t state;
    logic [3:0]   bitCnt;
    logic [7:0]   rxShift;
    logic [7:0]   txShift;
    logic [7:0]   ptr;
    logic         firstByte;
    logic         readMode;
    logic         acked;
    logic         sdaOe;
    logic         sdaOut;
    gsrp_req_t    req;
    logic         reqToggle;
    logic         ackMeta;
    logic         ackSync;
    logic         ackSeen;
    logic [7:0]   rdByte;
  } gsrp_link_t;

  // State of the memory side, clocked by the system clock.
  typedef struct packed {
    logic       reqMeta;
    logic       reqSync;
    logic       reqSeen;
    logic [7:0] rdData;
    logic       ackToggle;
  } gsrp_core_t;

  // True where an address falls into the factory memory window.
  function automatic logic gsrp_in_nvm(input logic [7:0] addr);
    return (addr >= NVM_BASE) && (addr <= NVM_LAST);
  endfunction : gsrp_in_nvm

endpackage : gsrp_pkg

// file: gsrp_nvm.sv
// Factory calibration memory, read only, as seen by the register port.
`timescale 1ns/100ps

module gsrp_nvm #(
  // Byte i of the window sits in bits 8*i+7 down to 8*i. Layout: cal
  // conditions, tracking id, resistances, slope, intercept. The default
  // content is arbitrary, a plain ramp that makes each byte recognisable.
  parameter logic [8*gsrp_pkg::NVM_BYTES-1:0] NVM_IMAGE =
    256'h1F1E1D1C1B1A191817161514131211100F0E0D0C0B0A09080706050403020100
) (
  input  wire logic [7:0] addr,
  output logic      [7:0] data
);

  logic [7:0] offset;

  // Addresses outside the window read as zero.
  always_comb begin
    offset = addr - gsrp_pkg::NVM_BASE;
    data   = 8'h00;
    if (gsrp_pkg::gsrp_in_nvm(addr)) begin
      data = NVM_IMAGE[8*offset +: 8];
    end
  end

endmodule : gsrp_nvm

// file: gsrp_port.sv
// Serial target port with a register pointer, RAM and factory memory.
`timescale 1ns/100ps

// Summary of operation
// - Follow bus clocks up to 400 kHz.
// - Answer seven-bit target address 33 hex.
// - First written byte loads the register pointer.
// - Pointer advances after every data byte written or read.
// - STOP ends the whole transaction.
// - Pointer wraps from FF to 00.
// - Writes go to RAM except 00 to 1F, where they are dropped; reads RAM and factory memory.
// - Scratch registers 88 to 8B read back writes.
// - Factory memory holds calibration and identity data.
module gsrp_port #(
  parameter logic [6:0] TARGET_ADDR = gsrp_pkg::TARGET_ADDR_DEFAULT
) (
  clk,
  reset_n,
  linkClk,
  scl,
  sdaIn,
  sdaOut,
  sdaOe
);

  input  wire logic clk;
  input  wire logic reset_n;
  input  wire logic linkClk;
  input  wire logic scl;
  input  wire logic sdaIn;
  output logic      sdaOut;
  output logic      sdaOe;

  gsrp_pkg::gsrp_link_t link_reg;
  gsrp_pkg::gsrp_link_t link_next;
  gsrp_pkg::gsrp_core_t core_reg;
  gsrp_pkg::gsrp_core_t core_next;

  // Register space backing store for all 256 pointer values, but 00 to 1F go to the factory memory.
  logic [7:0] ramMem [0:255];
  logic [7:0] nvmData;
  logic       sclRise;
  logic       sclFall;
  logic       startSeen;
  logic       stopSeen;
  logic       ackEvent;
  logic       newReq;
  logic       ramWrite;

  // Next pointer value after a transferred byte. A plain 8-bit add, so FF
  // rolls over to 00; the pointer never saturates at the top of the space.
  function automatic logic [7:0] ptrAdvance(input logic [7:0] p);
    return p + gsrp_pkg::PTR_STEP;
  endfunction : ptrAdvance

  // The factory memory is a lookup on the requested address.
  // It is combinational, so its byte is ready in the same system clock that sees the request.
  gsrp_nvm u_nvm (
    .addr (link_reg.req.addr),
    .data (nvmData)
  );

  // Bus edges and conditions come from the second synchroniser stage and
  // its delayed copy, never from the first stage.
  assign sclRise   = link_reg.sclSync & ~link_reg.sclPrev;
  assign sclFall   = ~link_reg.sclSync & link_reg.sclPrev;
  assign startSeen = link_reg.sclSync & link_reg.sclPrev &
                     link_reg.sdaPrev & ~link_reg.sdaSync;
  assign stopSeen  = link_reg.sclSync & link_reg.sclPrev &
                     ~link_reg.sdaPrev & link_reg.sdaSync;
  assign ackEvent  = link_reg.ackSync ^ link_reg.ackSeen;

  // Serial engine. It oversamples the bus on the link clock, so any bus
  // rate well below a sixteenth of that clock is followed.
  // With the link clock at 64 ns a fast-mode clock high phase spans about
  // nine link cycles, and the synchronisers use up two of them. A slower
  // link clock would shrink that margin below what the read fetch needs,
  // since the next byte is fetched from the memory side during the
  // acknowledge clock high time. There is no clock stretching, so a host
  // that runs the bus faster than the oversampling allows gets stale read
  // data rather than a held clock.
  always_comb begin
    link_next          = link_reg;
    link_next.sclMeta  = scl;
    link_next.sclSync  = link_reg.sclMeta;
    link_next.sclPrev  = link_reg.sclSync;
    link_next.sdaMeta  = sdaIn;
    link_next.sdaSync  = link_reg.sdaMeta;
    link_next.sdaPrev  = link_reg.sdaSync;
    link_next.sdaOut   = 1'b0;
    link_next.ackMeta  = core_reg.ackToggle;
    link_next.ackSync  = link_reg.ackMeta;
    link_next.ackSeen  = link_reg.ackSync;
    // Read data is held by the memory side until the next request.
    if (ackEvent) begin
      link_next.rdByte = core_reg.rdData;
    end
    if (stopSeen) begin
      // Release the bus and drop out of any transfer.
      link_next.state = gsrp_pkg::LS_IDLE;
      link_next.sdaOe = 1'b0;
    end else if (startSeen) begin
      // A repeated start keeps the pointer for the read phase.
      link_next.state   = gsrp_pkg::LS_ADDR;
      link_next.bitCnt  = gsrp_pkg::BIT_CNT_ZERO;
      link_next.sdaOe   = 1'b0;
    end else begin
      case (link_reg.state)
        gsrp_pkg::LS_IDLE: begin
          // Nothing to do until a START; keep the line released.
          link_next.sdaOe = 1'b0;
        end
        gsrp_pkg::LS_ADDR: begin
          if (sclRise) begin
            link_next.rxShift = {link_reg.rxShift[6:0], link_reg.sdaSync};
            link_next.bitCnt  = link_reg.bitCnt + gsrp_pkg::BIT_CNT_ONE;
          end else if (sclFall &&
                       link_reg.bitCnt == gsrp_pkg::BIT_CNT_BYTE) begin
            if (link_reg.rxShift[7:1] == TARGET_ADDR) begin
              // Pull the line low for the address acknowledge.
              link_next.sdaOe     = 1'b1;
              link_next.readMode  = link_reg.rxShift[0];
              link_next.firstByte = 1'b1;
              link_next.state     = gsrp_pkg::LS_ADDRACK;
              if (link_reg.rxShift[0]) begin
                // Fetch the byte at the pointer during the acknowledge.
                link_next.req.write = 1'b0;
                link_next.req.addr  = link_reg.ptr;
                link_next.reqToggle = ~link_reg.reqToggle;
              end
            end else begin
              // Another target is addressed; stay off the bus.
              link_next.state = gsrp_pkg::LS_IDLE;
            end
          end
        end
        gsrp_pkg::LS_ADDRACK: begin
          // The host clocks the acknowledge; its fall starts the data phase.
          if (sclFall) begin
            link_next.bitCnt = gsrp_pkg::BIT_CNT_ZERO;
            if (link_reg.readMode) begin
              // Drive the first data bit, most significant first.
              link_next.sdaOe   = ~link_reg.rdByte[7];
              link_next.txShift = {link_reg.rdByte[6:0], 1'b0};
              link_next.bitCnt  = gsrp_pkg::BIT_CNT_ONE;
              link_next.state   = gsrp_pkg::LS_RDATA;
            end else begin
              link_next.sdaOe = 1'b0;
              link_next.state = gsrp_pkg::LS_WDATA;
            end
          end
        end
        gsrp_pkg::LS_WDATA: begin
          if (sclRise) begin
            link_next.rxShift = {link_reg.rxShift[6:0], link_reg.sdaSync};
            link_next.bitCnt  = link_reg.bitCnt + gsrp_pkg::BIT_CNT_ONE;
          end else if (sclFall &&
                       link_reg.bitCnt == gsrp_pkg::BIT_CNT_BYTE) begin
            link_next.sdaOe  = 1'b1;
            link_next.state  = gsrp_pkg::LS_WACK;
            link_next.bitCnt = gsrp_pkg::BIT_CNT_ZERO;
            if (link_reg.firstByte) begin
              // The first byte of a write only moves the pointer.
              link_next.ptr       = link_reg.rxShift;
              link_next.firstByte = 1'b0;
            end else begin
              link_next.req.write = 1'b1;
              link_next.req.addr  = link_reg.ptr;
              link_next.req.data  = link_reg.rxShift;
              link_next.reqToggle = ~link_reg.reqToggle;
              // Plain 8-bit add, so FF rolls over to 00.
              link_next.ptr       = ptrAdvance(link_reg.ptr);
            end
          end
        end
        gsrp_pkg::LS_WACK: begin
          // Hold the acknowledge through its clock, release on the fall.
          if (sclFall) begin
            link_next.sdaOe = 1'b0;
            link_next.state = gsrp_pkg::LS_WDATA;
          end
        end
        gsrp_pkg::LS_RDATA: begin
          // Each clock fall puts out the next bit; the pin only pulls low.
          if (sclFall) begin
            if (link_reg.bitCnt == gsrp_pkg::BIT_CNT_BYTE) begin
              // Let go so the host can answer the byte.
              link_next.sdaOe = 1'b0;
              link_next.state = gsrp_pkg::LS_RACK;
            end else begin
              link_next.sdaOe   = ~link_reg.txShift[7];
              link_next.txShift = {link_reg.txShift[6:0], 1'b0};
              link_next.bitCnt  = link_reg.bitCnt + gsrp_pkg::BIT_CNT_ONE;
            end
          end
        end
        gsrp_pkg::LS_RACK: begin
          if (sclRise) begin
            // The byte is out whether or not the host takes more.
            link_next.ptr   = ptrAdvance(link_reg.ptr);
            link_next.acked = ~link_reg.sdaSync;
            if (!link_reg.sdaSync) begin
              // Fetch now; the clock high time covers the round trip.
              link_next.req.write = 1'b0;
              link_next.req.addr  = ptrAdvance(link_reg.ptr);
              link_next.reqToggle = ~link_reg.reqToggle;
            end
          end else if (sclFall) begin
            if (link_reg.acked) begin
              link_next.sdaOe   = ~link_reg.rdByte[7];
              link_next.txShift = {link_reg.rdByte[6:0], 1'b0};
              link_next.bitCnt  = gsrp_pkg::BIT_CNT_ONE;
              link_next.state   = gsrp_pkg::LS_RDATA;
            end else begin
              // A refused byte ends the burst; wait for STOP or START.
              link_next.state = gsrp_pkg::LS_IDLE;
            end
          end
        end
        default: begin
          // An illegal state code falls back to idle with the line released.
          link_next.state = gsrp_pkg::LS_IDLE;
          link_next.sdaOe = 1'b0;
        end
      endcase
    end
  end

  // Serial engine registers. The bus sits idle high after reset.
  // Presetting the synchronisers high keeps a false START or clock edge
  // from appearing right after the release.
  always_ff @(posedge linkClk or negedge reset_n) begin
    if (!reset_n) begin
      link_reg           <= '0;
      link_reg.sclMeta   <= 1'b1;
      link_reg.sclSync   <= 1'b1;
      link_reg.sclPrev   <= 1'b1;
      link_reg.sdaMeta   <= 1'b1;
      link_reg.sdaSync   <= 1'b1;
      link_reg.sdaPrev   <= 1'b1;
      link_reg.state     <= gsrp_pkg::LS_IDLE;
      link_reg.ptr       <= gsrp_pkg::PTR_FIRST;
    end else begin
      link_reg <= link_next;
    end
  end

  // Memory side. A request is marked by a toggle and its payload is held
  // until it is answered, so the payload is safe to read once the toggle
  // has passed the two synchroniser stages.
  // The trade is latency: a request takes two or three system clocks to
  // be seen and the answer three link clocks to come back, which the bus
  // timing hides, in exchange for no multi-bit word ever being sampled
  // while it moves.
  assign newReq   = core_reg.reqSync ^ core_reg.reqSeen;
  assign ramWrite = newReq & link_reg.req.write &
                    ~gsrp_pkg::gsrp_in_nvm(link_reg.req.addr);

  always_comb begin
    core_next         = core_reg;
    core_next.reqMeta = link_reg.reqToggle;
    core_next.reqSync = core_reg.reqMeta;
    core_next.reqSeen = core_reg.reqSync;
    if (newReq) begin
      // Reads see factory memory in its window and RAM elsewhere.
      if (gsrp_pkg::gsrp_in_nvm(link_reg.req.addr)) begin
        core_next.rdData = nvmData;
      end else begin
        core_next.rdData = ramMem[link_reg.req.addr];
      end
      core_next.ackToggle = ~core_reg.ackToggle;
    end
  end

  // Memory side registers; read data is held until the next request.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_reg <= '0;
    end else begin
      core_reg <= core_next;
    end
  end

  // Writes into the factory window are dropped; the memory is read only.
  // RAM holds no reset, so a byte reads back only after it was written.
  // A write into the factory window is acknowledged on the bus all the
  // same; the host gets no sign that the byte was dropped.
  always_ff @(posedge clk) begin
    if (ramWrite) begin
      ramMem[link_reg.req.addr] <= link_reg.req.data;
    end
  end

  // Open-drain data pin: the output level is always low, the enable pulls.
  // Both come straight from link flip-flops, so no glitch from the
  // next-state logic reaches the pad.
  assign sdaOut = link_reg.sdaOut;
  assign sdaOe  = link_reg.sdaOe;

endmodule : gsrp_port

// file: gsrp_port_checker.sv
// Pin-level assertions for the gas sensor register port.
`timescale 1ns/100ps
module gsrp_port_checker #(
  parameter logic [6:0] TARGET_ADDR = gsrp_pkg::TARGET_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic linkClk,
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe
);
  logic       sclP;
  logic       sdaP;
  logic       idle;
  logic       rd;
  logic       mis;
  logic       inAddr;
  logic [3:0] cnt;
  logic [7:0] sh;
  wire        rise   = scl && !sclP;
  wire        fall   = !scl && sclP;
  wire        startC = scl && sclP && sdaP && !sdaIn;
  wire        stopC  = scl && sclP && !sdaP && sdaIn;

  // Tracks the bit slot and the captured byte straight from the pins.
  // The count is 9 between the acknowledge rise and the next byte.
  always_ff @(posedge linkClk or negedge reset_n) begin
    if (!reset_n) begin
      sclP <= 1'b1;
      sdaP <= 1'b1;
      idle <= 1'b1;
      rd <= 1'b0;
      mis <= 1'b0;
      inAddr <= 1'b1;
      cnt <= 4'h0;
      sh <= 8'h00;
    end else begin
      sclP <= scl;
      sdaP <= sdaIn;
      if (startC) begin
        idle <= 1'b0;
        rd <= 1'b0;
        mis <= 1'b0;
        inAddr <= 1'b1;
        cnt <= 4'h0;
      end else if (stopC) begin
        idle <= 1'b1;
      end else if (rise) begin
        cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
        if (cnt == 4'h9) inAddr <= 1'b0;
        if (cnt != 4'h8) sh <= {sh[6:0], sdaIn};
        if (cnt == 4'h8 && inAddr) begin
          rd <= sh[0];
          mis <= (sh[7:1] != TARGET_ADDR);
        end
      end
    end
  end

  default clocking cb @(posedge linkClk); endclocking
  default disable iff (!reset_n);

  a_out_low: assert property (sdaOe |-> sdaOut == 1'b0)
    else $error("data output high while enabled");
  a_oe_scl_low: assert property ($changed(sdaOe) |-> !scl && !sclP)
    else $error("data enable changed while clock high");
  a_addr_ack: assert property (rise && cnt == 4'h8 && inAddr |->
    sdaOe == (sh[7:1] == TARGET_ADDR)) else $error("address answer wrong");
  a_wr_ack: assert property (rise && cnt == 4'h8 && !inAddr && !rd &&
    !mis && !idle |-> sdaOe) else $error("written byte not acknowledged");
  a_ack_end: assert property (fall && cnt == 4'h9 && !rd |->
    ##[1:6] !sdaOe) else $error("acknowledge not released");
  a_host_ack: assert property (rise && cnt == 4'h8 && rd && !inAddr |->
    !sdaOe) else $error("host acknowledge slot driven");
  a_rx_quiet: assert property (rise && ((inAddr && cnt < 4'h8) ||
    (!rd && cnt != 4'h8)) |-> !sdaOe) else $error("driven while receiving");
  a_mis_quiet: assert property (mis |-> !sdaOe)
    else $error("driven for another address");
  a_stop_quiet: assert property (idle |-> !sdaOe)
    else $error("driven after stop");

  c_rd_addr: cover property (rise && cnt == 4'h8 && inAddr && sh[0] && sdaOe);
  c_mis: cover property ($rose(mis));
  c_stop: cover property (stopC ##1 idle);
endmodule : gsrp_port_checker

bind gsrp_port gsrp_port_checker #(.TARGET_ADDR(TARGET_ADDR)) u_chk (
  .clk(clk), .reset_n(reset_n), .linkClk(linkClk), .scl(scl),
  .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe));

// file: gsrp_host_model.sv
// Bus controller model that makes the clock and pulls the data wire.
`timescale 1ns/100ps
module gsrp_host_model (
  scl,
  hostPull,
  sda
);
  output logic      scl;
  output logic      hostPull;
  input  wire logic sda;
  logic [7:0]       rxVal;
  event             gotEv;

  // Bus idle: clock high, data released to its pull-up.
  initial begin
    scl = 1'b1;
    hostPull = 1'b0;
  end

  // One bit: 400 ns setup, 608 ns high, 1896 ns low, just under 400 kHz.
  task automatic bitSlot(input logic b, output logic r);
    hostPull = ~b;
    #400 scl = 1'b1;
    #304 r = sda;
    #304 scl = 1'b0;
    #1496;
  endtask : bitSlot

  // Start, or repeated start when the clock is low.
  task automatic start();
    hostPull = 1'b0;
    #400 scl = 1'b1;
    #400 hostPull = 1'b1;
    #400 scl = 1'b0;
    #400;
  endtask : start

  // Stop ends the transaction; bus free time follows.
  task automatic stop();
    hostPull = 1'b1;
    #400 scl = 1'b1;
    #400 hostPull = 1'b0;
    #1304;
  endtask : stop

  // Byte, MSB first. Writes report the acknowledge level in bit 0; reads
  // report data and end with a host NACK on the last byte.
  task automatic xfer(input logic [7:0] d, input logic rd, input logic last);
    logic [7:0] r;
    logic       a;
    for (int i = 7; i >= 0; i--) begin
      bitSlot(rd ? 1'b1 : d[i], r[i]);
    end
    bitSlot(rd ? last : 1'b1, a);
    rxVal = rd ? r : {7'h00, a};
    -> gotEv;
  endtask : xfer
endmodule : gsrp_host_model

// file: gsrp_port_tb_top.sv
// Self-checking testbench for the gas sensor register port.
`timescale 1ns/100ps
module gsrp_port_tb_top;
  localparam logic [6:0] A = gsrp_pkg::TARGET_ADDR_DEFAULT;
  logic       clk = 1'b0;
  logic       linkClk = 1'b0;
  logic       reset_n;
  logic       scl;
  logic       hostPull;
  logic       sda;
  logic       sdaOut;
  logic       sdaOe;
  logic [7:0] expQ[$];
  logic [7:0] scr[4];
  int         n_mismatch = 0;
  int         checks = 0;
  int         cycles = 0;
  integer     seed = 32'hD0135F15;

  // Open-drain wire with a pull-up; any pulling party wins.
  assign sda = ((sdaOe && !sdaOut) || hostPull) ? 1'b0 : 1'b1;

  // Clocks: link edges fall 4 ns off the bus timing grid to avoid races.
  always #4 clk = ~clk;
  initial begin
    #17;
    forever #32 linkClk = ~linkClk;
  end

  gsrp_port #(.TARGET_ADDR(A)) dut (.clk(clk), .reset_n(reset_n),
    .linkClk(linkClk), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOe(sdaOe));
  gsrp_host_model host (.scl(scl), .hostPull(hostPull), .sda(sda));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    if (expQ.size() != 0) n_mismatch++;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  // Each finished byte is compared with the oldest expectation.
  always @(host.gotEv) begin
    chk(host.rxVal, expQ.pop_front());
  end

  // The run is cut short at 95000 system clocks, about 760 us, only a little above the expected 730 us.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic doReset();
    reset_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge linkClk);
    @(posedge clk);
    #1;
  endtask : doReset

  // A written byte expects the port to acknowledge it.
  task automatic send(input logic [7:0] b);
    expQ.push_back(8'h00);
    host.xfer(b, 1'b0, 1'b0);
  endtask : send

  task automatic wrBurst(input logic [7:0] p, input logic [7:0] d[$]);
    host.start();
    send({A, 1'b0});
    send(p);
    foreach (d[i]) send(d[i]);
    host.stop();
  endtask : wrBurst

  // Optional pointer write, repeated start, then a read burst.
  task automatic rdBurst(input logic setP, input logic [7:0] p,
                         input logic [7:0] e[$]);
    host.start();
    if (setP) begin
      send({A, 1'b0});
      send(p);
      host.start();
    end
    send({A, 1'b1});
    foreach (e[i]) begin
      expQ.push_back(e[i]);
      host.xfer(8'hFF, 1'b1, i == e.size() - 1);
    end
    host.stop();
  endtask : rdBurst

  initial begin
    doReset();
    foreach (scr[i]) scr[i] = 8'($random(seed));
    // Scratch burst with auto-increment, read back in one burst.
    wrBurst(gsrp_pkg::SCRATCH_TEST_0_OFS, '{scr[0], scr[1], scr[2], scr[3]});
    rdBurst(1'b1, gsrp_pkg::SCRATCH_TEST_0_OFS, '{scr[0], scr[1], scr[2], scr[3]});
    // Factory bytes hold their own offset with the default image.
    rdBurst(1'b1, gsrp_pkg::NVM_TRACK_ID_OFS, '{8'h04, 8'h05});
    // Pointer wraps to 00, where the factory byte ignores the write.
    wrBurst(gsrp_pkg::PTR_LAST, '{~scr[0], scr[1]});
    rdBurst(1'b1, gsrp_pkg::PTR_LAST, '{~scr[0], 8'h00});
    // Another address is left unanswered.
    host.start();
    expQ.push_back(8'h01);
    host.xfer({A + 7'h01, 1'b0}, 1'b0, 1'b0);
    host.stop();
    // Power cycle after scratch use; pointer restarts at 00.
    doReset();
    rdBurst(1'b0, 8'h00, '{8'h00, 8'h01});
    repeat (10) @(posedge clk);
    test_done();
  end
endmodule : gsrp_port_tb_top
